// *** logic/type_b_frame_regs.svh ***
`ifndef TYPE_B_FRAME_REGS_SVH
`define TYPE_B_FRAME_REGS_SVH

// ----------------------------------------------------------------------
// Clock and air-interface timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
// One elementary time unit, 9.44 us.
`define ETU_NS 9440
`define ETU_CYC (`ETU_NS / `CLK_PERIOD_NS)
// One 847 kHz subcarrier period, rounded down to whole nanoseconds.
`define SUBC_NS 1180
`define SUBC_CYC (`SUBC_NS / `CLK_PERIOD_NS)
`define SUBC_HALF_CYC (`SUBC_CYC / 2)
// Guard and synchronisation intervals, in subcarrier periods.
`define GUARD_SUBC 128
`define SYNC_SUBC 128
`define GUARD_CYC (`GUARD_SUBC * `SUBC_CYC)
`define SYNC_CYC (`SYNC_SUBC * `SUBC_CYC)

// ----------------------------------------------------------------------
// Frame delimiters, in elementary time units
// ----------------------------------------------------------------------
`define DELIM_LOW_ETU 10
`define SOF_HIGH_MIN_ETU 2
`define SOF_HIGH_MAX_ETU 3
`define GAP_MAX_ETU 6
`define CHAR_BITS 10
`define DELIM_BITS 12
// Delimiter pattern, sent bit 0 first: ten zeros, then two ones.
`define DELIM_PATTERN 12'hc00

// ----------------------------------------------------------------------
// CRC
// ----------------------------------------------------------------------
`define CRC_PRESET 16'hffff
`define CRC_POLY 16'h8408
`define CRC_RESIDUE 16'hf0b8

// ----------------------------------------------------------------------
// Buffering
// ----------------------------------------------------------------------
`define TX_FIFO_DEPTH 8

`endif

// *** logic/type_b_frame_pkg.sv ***
package type_b_frame_pkg;

  // Answer byte handed in by the command layer.
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } tx_word_t;

  // Receive-side events, all one-cycle pulses except data.
  typedef struct packed {
    logic byte_valid;
    logic frame_ok;
    logic frame_bad;
    logic [7:0] data;
  } rx_event_t;

  typedef enum logic [2:0] {
    R_IDLE = 3'h0,
    R_SOF_LOW = 3'h1,
    R_SOF_HIGH = 3'h3,
    R_CHAR = 3'h2,
    R_GAP = 3'h6,
    R_EOF = 3'h7
  } rx_state_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'h0,
    T_GUARD = 3'h1,
    T_WAIT = 3'h3,
    T_SYNC = 3'h2,
    T_SEND = 3'h6,
    T_POST = 3'h7
  } tx_state_t;

  typedef enum logic [2:0] {
    P_DATA = 3'h0,
    P_CRC_LO = 3'h1,
    P_CRC_HI = 3'h3,
    P_EOF = 3'h2,
    P_END = 3'h6
  } tx_phase_t;

endpackage : type_b_frame_pkg

// *** logic/word_fifo.sv ***
`timescale 1ns/1ps

module word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Fill side
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  // Drain side
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid_in & in_ready_out;
  assign pop = out_ready_in & out_valid_out;
  assign out_data_out = mem[rd_ptr_reg];
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  // Flags are registered so that neither side sees a combinational path.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      in_ready_out <= (count_next != (AW+1)'(DEPTH));
      out_valid_out <= (count_next != '0);
    end
  end

endmodule : word_fifo

// *** logic/type_b_frame_layer.sv ***
// Operation
// - Each byte travels as a ten-bit character, bit zero first.
// - Each bit lasts one time unit of 9.44 microseconds.
// - Character position zero is a start bit at logic zero.
// - Positions one to eight carry the byte, least significant bit first.
// - Position nine is a stop bit at logic one.
// - Answer opens: fall, ten units low, two units high.
// - Answer closes: fall, ten units low, two units high.
// - On any receive error, nothing executes and no error answer goes.
// - Answer holds opener, data, two CRC bytes, closer, same characters.
// - No modulation for 128 subcarrier periods after every frame.
// - Then 128 periods plain subcarrier; next phase flip starts the opener.
// - Answer bits are BPSK on an 847 kHz subcarrier.
// - CRC is sixteen bits, preset to all ones.
// - Two CRC bytes precede the closer, covering all bytes before them.
// - A request with bad CRC is dropped silently, unanswered.
// - CRC goes low byte first, each byte least significant bit first.
`timescale 1ns/1ps
`include "type_b_frame_regs.svh"

module type_b_frame_layer #(
  parameter int GUARD_CYC = `GUARD_CYC,
  parameter int SYNC_CYC = `SYNC_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // Demodulated request level, 1 while the carrier is unmodulated
  input wire logic rx_level_in,
  // Received request bytes and frame verdicts
  output type_b_frame_pkg::rx_event_t rx_event_out,
  // Answer bytes from the command layer
  input wire type_b_frame_pkg::tx_word_t tx_word_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  // Load modulator drive
  output logic mod_out,
  output logic mod_active_out,
  output logic tx_busy_out
);
  import type_b_frame_pkg::*;

  // ----------------------------------------------------------------------
  // Constants and helpers
  // ----------------------------------------------------------------------
  localparam logic [15:0] ETU = 16'(`ETU_CYC);
  localparam logic [15:0] HALF_ETU = 16'(`ETU_CYC / 2);
  localparam logic [15:0] SOF_LOW_MIN = 16'((`DELIM_LOW_ETU * `ETU_CYC)
                                            - (`ETU_CYC / 2));
  localparam logic [15:0] SOF_LOW_MAX = 16'((`DELIM_LOW_ETU * `ETU_CYC)
                                            + (`ETU_CYC / 2));
  localparam logic [15:0] SOF_HI_MIN = 16'((`SOF_HIGH_MIN_ETU * `ETU_CYC)
                                           - (`ETU_CYC / 2));
  localparam logic [15:0] SOF_HI_MAX = 16'((`SOF_HIGH_MAX_ETU * `ETU_CYC)
                                           + (`ETU_CYC / 2));
  localparam logic [15:0] GAP_MAX = 16'(`GAP_MAX_ETU * `ETU_CYC);
  localparam logic [15:0] EOF_RISE_MAX = 16'(2 * `ETU_CYC);
  localparam logic [6:0] SUBC = 7'(`SUBC_CYC);
  localparam logic [6:0] SUBC_HALF = 7'(`SUBC_HALF_CYC);

  function automatic logic [15:0] crc_byte(input logic [15:0] crc,
                                           input logic [7:0] d);
    logic [15:0] c;
    c = crc ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_byte

  // Start bit, byte, stop bit; the first bit sent is the start bit.
  function automatic logic [11:0] char_pattern(input logic [7:0] d);
    return {2'b00, 1'b1, d, 1'b0};
  endfunction : char_pattern

  // ----------------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------------
  logic [2:0] sync_reg;
  logic level_reg;
  logic level_prev_reg;
  logic fall;
  logic rise;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sync_reg <= 3'h7;
      level_reg <= 1'b1;
      level_prev_reg <= 1'b1;
    end else begin
      sync_reg <= {sync_reg[1:0], rx_level_in};
      if (sync_reg[1] == sync_reg[2]) begin
        level_reg <= sync_reg[2];
      end
      level_prev_reg <= level_reg;
    end
  end

  assign fall = level_prev_reg & ~level_reg;
  assign rise = ~level_prev_reg & level_reg;

  // ----------------------------------------------------------------------
  // Request receiver
  // ----------------------------------------------------------------------
  rx_state_t rx_state_reg;
  tx_state_t tx_state_reg;
  logic [15:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  logic [15:0] rx_crc_reg;
  logic [7:0] hold0_reg;
  logic [7:0] hold1_reg;
  logic [1:0] rx_count_reg;
  logic rx_enable;
  logic sample;
  logic bit_end;
  logic crc_good;

  // Receiving is shut off while the tag modulates and during the quiet time after it.
  assign rx_enable = (tx_state_reg == T_IDLE) | (tx_state_reg == T_GUARD)
                     | (tx_state_reg == T_WAIT);
  assign sample = (rx_cnt_reg == HALF_ETU);
  assign bit_end = (rx_cnt_reg == ETU - 16'h0001);
  // Running the CRC across its own complemented bytes leaves a fixed residue.
  assign crc_good = (rx_crc_reg == `CRC_RESIDUE) & (rx_count_reg == 2'h2);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rx_state_reg <= R_IDLE;
      rx_cnt_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_crc_reg <= `CRC_PRESET;
      hold0_reg <= 8'h00;
      hold1_reg <= 8'h00;
      rx_count_reg <= 2'h0;
      rx_event_out <= '0;
    end else begin
      rx_event_out.byte_valid <= 1'b0;
      rx_event_out.frame_ok <= 1'b0;
      rx_event_out.frame_bad <= 1'b0;
      rx_cnt_reg <= rx_cnt_reg + 16'h0001;
      if (!rx_enable) begin
        rx_state_reg <= R_IDLE;
      end else begin
        case (rx_state_reg)
          R_IDLE: begin
            if (fall) begin
              rx_state_reg <= R_SOF_LOW;
              rx_cnt_reg <= 16'h0000;
            end
          end
          R_SOF_LOW: begin
            // A short low is noise, not a frame, so it is ignored.
            if (rise) begin
              rx_cnt_reg <= 16'h0000;
              rx_state_reg <= (rx_cnt_reg >= SOF_LOW_MIN)
                              ? R_SOF_HIGH : R_IDLE;
            end else if (rx_cnt_reg > SOF_LOW_MAX) begin
              rx_state_reg <= R_IDLE;
            end
          end
          R_SOF_HIGH: begin
            rx_crc_reg <= `CRC_PRESET;
            rx_count_reg <= 2'h0;
            if (fall) begin
              rx_cnt_reg <= 16'h0000;
              rx_bit_reg <= 4'h0;
              if (rx_cnt_reg >= SOF_HI_MIN) begin
                rx_state_reg <= R_CHAR;
              end else begin
                rx_state_reg <= R_IDLE;
                rx_event_out.frame_bad <= 1'b1;
              end
            end else if (rx_cnt_reg > SOF_HI_MAX) begin
              rx_state_reg <= R_IDLE;
              rx_event_out.frame_bad <= 1'b1;
            end
          end
          R_CHAR: begin
            if (bit_end) begin
              rx_cnt_reg <= 16'h0000;
              rx_bit_reg <= rx_bit_reg + 4'h1;
            end
            if (sample) begin
              if (rx_bit_reg == 4'h0) begin
                if (level_reg) begin
                  rx_state_reg <= R_IDLE;
                  rx_event_out.frame_bad <= 1'b1;
                end
              end else if (rx_bit_reg < 4'h9) begin
                rx_shift_reg <= {level_reg, rx_shift_reg[7:1]};
              end else if (level_reg) begin
                // Stop bit seen: the byte is complete.
                rx_state_reg <= R_GAP;
                rx_cnt_reg <= 16'h0000;
                rx_crc_reg <= crc_byte(rx_crc_reg, rx_shift_reg);
                hold0_reg <= rx_shift_reg;
                hold1_reg <= hold0_reg;
                // The last two bytes are CRC and are never passed on.
                if (rx_count_reg == 2'h2) begin
                  rx_event_out.byte_valid <= 1'b1;
                  rx_event_out.data <= hold1_reg;
                end else begin
                  rx_count_reg <= rx_count_reg + 2'h1;
                end
              end else if (rx_shift_reg == 8'h00) begin
                rx_state_reg <= R_EOF;
                rx_cnt_reg <= 16'h0000;
              end else begin
                rx_state_reg <= R_IDLE;
                rx_event_out.frame_bad <= 1'b1;
              end
            end
          end
          R_GAP: begin
            if (fall) begin
              rx_state_reg <= R_CHAR;
              rx_cnt_reg <= 16'h0000;
              rx_bit_reg <= 4'h0;
            end else if (rx_cnt_reg > GAP_MAX) begin
              rx_state_reg <= R_IDLE;
              rx_event_out.frame_bad <= 1'b1;
            end
          end
          R_EOF: begin
            // Frame ends on the rise; a bad CRC gets no answer at all.
            if (rise) begin
              rx_state_reg <= R_IDLE;
              rx_event_out.frame_ok <= crc_good;
              rx_event_out.frame_bad <= ~crc_good;
            end else if (rx_cnt_reg > EOF_RISE_MAX) begin
              rx_state_reg <= R_IDLE;
              rx_event_out.frame_bad <= 1'b1;
            end
          end
          default: rx_state_reg <= R_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Answer buffer
  // ----------------------------------------------------------------------
  tx_word_t fifo_word;
  logic fifo_valid;
  logic fifo_pop;

  word_fifo #(
    .WIDTH($bits(tx_word_t)),
    .DEPTH(`TX_FIFO_DEPTH)
  ) answer_fifo (
    .clk_in(core_clk_in),
    .reset_in(reset_in),
    .in_data_in(tx_word_in),
    .in_valid_in(tx_valid_in),
    .in_ready_out(tx_ready_out),
    .out_data_out(fifo_word),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop)
  );

  // ----------------------------------------------------------------------
  // Answer transmitter
  // ----------------------------------------------------------------------
  tx_phase_t tx_phase_reg;
  logic [15:0] tmr_reg;
  logic [15:0] etu_cnt_reg;
  logic [6:0] sc_cnt_reg;
  logic [11:0] tx_shift_reg;
  logic [3:0] tx_bits_reg;
  logic [15:0] tx_crc_reg;
  logic subcarrier;
  logic etu_end;
  logic load_next;
  logic [15:0] crc_out;

  assign subcarrier = (sc_cnt_reg < SUBC_HALF);
  assign etu_end = (etu_cnt_reg == ETU - 16'h0001);
  assign load_next = (tx_state_reg == T_SEND) & etu_end
                     & (tx_bits_reg == 4'h1);
  assign fifo_pop = load_next & (tx_phase_reg == P_DATA) & fifo_valid;
  assign crc_out = ~tx_crc_reg;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tx_state_reg <= T_IDLE;
      tx_phase_reg <= P_DATA;
      tmr_reg <= 16'h0000;
      etu_cnt_reg <= 16'h0000;
      sc_cnt_reg <= 7'h00;
      tx_shift_reg <= 12'hfff;
      tx_bits_reg <= 4'h0;
      tx_crc_reg <= `CRC_PRESET;
    end else begin
      tmr_reg <= tmr_reg + 16'h0001;
      sc_cnt_reg <= (sc_cnt_reg == SUBC - 7'h01) ? 7'h00 : sc_cnt_reg + 7'h01;
      etu_cnt_reg <= etu_end ? 16'h0000 : etu_cnt_reg + 16'h0001;
      case (tx_state_reg)
        T_IDLE: begin
          if (rx_event_out.frame_ok) begin
            tx_state_reg <= T_GUARD;
            tmr_reg <= 16'h0000;
          end
        end
        T_GUARD: begin
          if (rx_state_reg != R_IDLE) begin
            tx_state_reg <= T_IDLE;
          end else if (tmr_reg >= 16'(GUARD_CYC - 1)) begin
            tx_state_reg <= T_WAIT;
          end
        end
        T_WAIT: begin
          // A new request before the answer arrives cancels the answer.
          if (rx_state_reg != R_IDLE) begin
            tx_state_reg <= T_IDLE;
          end else if (fifo_valid) begin
            tx_state_reg <= T_SYNC;
            tmr_reg <= 16'h0000;
            sc_cnt_reg <= 7'h00;
          end
        end
        T_SYNC: begin
          if (tmr_reg >= 16'(SYNC_CYC - 1)) begin
            tx_state_reg <= T_SEND;
            etu_cnt_reg <= 16'h0000;
            tx_shift_reg <= `DELIM_PATTERN;
            tx_bits_reg <= 4'(`DELIM_BITS);
            tx_phase_reg <= P_DATA;
            tx_crc_reg <= `CRC_PRESET;
          end
        end
        T_SEND: begin
          if (etu_end) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
            tx_bits_reg <= tx_bits_reg - 4'h1;
          end
          if (load_next) begin
            tx_bits_reg <= 4'(`CHAR_BITS);
            case (tx_phase_reg)
              P_DATA: begin
                if (fifo_valid) begin
                  tx_shift_reg <= char_pattern(fifo_word.data);
                  tx_crc_reg <= crc_byte(tx_crc_reg, fifo_word.data);
                  tx_phase_reg <= fifo_word.last ? P_CRC_LO : P_DATA;
                end else begin
                  // Underrun: hold logic one between characters.
                  tx_shift_reg <= 12'hfff;
                  tx_bits_reg <= 4'h1;
                end
              end
              P_CRC_LO: begin
                tx_shift_reg <= char_pattern(crc_out[7:0]);
                tx_phase_reg <= P_CRC_HI;
              end
              P_CRC_HI: begin
                tx_shift_reg <= char_pattern(crc_out[15:8]);
                tx_phase_reg <= P_EOF;
              end
              P_EOF: begin
                tx_shift_reg <= `DELIM_PATTERN;
                tx_bits_reg <= 4'(`DELIM_BITS);
                tx_phase_reg <= P_END;
              end
              default: begin
                tx_state_reg <= T_POST;
                tmr_reg <= 16'h0000;
              end
            endcase
          end
        end
        T_POST: begin
          // Quiet after the answer too, so the reader can turn round.
          if (tmr_reg >= 16'(GUARD_CYC - 1)) begin
            tx_state_reg <= T_IDLE;
          end
        end
        default: tx_state_reg <= T_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Modulator outputs
  // ----------------------------------------------------------------------
  // Logic one keeps the synchronisation phase; logic zero inverts it.
  logic mod_next;
  logic active_next;

  assign active_next = (tx_state_reg == T_SYNC) | (tx_state_reg == T_SEND);
  assign mod_next = active_next
                    & (subcarrier ^ ((tx_state_reg == T_SEND)
                                     & ~tx_shift_reg[0]));

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mod_out <= 1'b0;
      mod_active_out <= 1'b0;
      tx_busy_out <= 1'b0;
    end else begin
      mod_out <= mod_next;
      mod_active_out <= active_next;
      tx_busy_out <= (tx_state_reg != T_IDLE);
    end
  end

endmodule : type_b_frame_layer

// *** testbench/frame_layer_sva.sv ***
`timescale 1ns/1ps

module frame_layer_sva #(
  parameter int GUARD_CYC = 1888
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire type_b_frame_pkg::rx_event_t rx_event_out,
  input wire logic mod_out,
  input wire logic mod_active_out,
  input wire logic tx_busy_out
);
  import type_b_frame_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  int quiet_reg;
  // Counts down the quiet interval armed by each good request.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      quiet_reg <= 0;
    end else if (rx_event_out.frame_ok) begin
      quiet_reg <= GUARD_CYC;
    end else if (quiet_reg != 0) begin
      quiet_reg <= quiet_reg - 1;
    end
  end
  a_guard_quiet: assert property (
    quiet_reg != 0 |-> !mod_active_out)
    else $error("modulation inside guard interval");
  // The verdict pulse is seen one edge later, busy one edge after that.
  a_ok_arms_tx: assert property (
    rx_event_out.frame_ok |-> ##2 tx_busy_out)
    else $error("good request did not start the answer");
  a_bad_no_tx: assert property (
    rx_event_out.frame_bad && !tx_busy_out |-> ##2 !tx_busy_out)
    else $error("bad request started an answer");
  a_ok_bad_apart: assert property (
    !(rx_event_out.frame_ok && rx_event_out.frame_bad))
    else $error("frame judged good and bad at once");
  a_ok_pulse: assert property (
    rx_event_out.frame_ok |=> !rx_event_out.frame_ok)
    else $error("frame_ok longer than one cycle");
  a_byte_pulse: assert property (
    rx_event_out.byte_valid |=> !rx_event_out.byte_valid)
    else $error("byte_valid longer than one cycle");
  a_active_busy: assert property (mod_active_out |-> tx_busy_out)
    else $error("modulating while idle");
  a_quiet_line: assert property (
    !mod_active_out && !$past(mod_active_out) |-> !mod_out)
    else $error("modulator driven outside the answer");
  a_sync_high: assert property (
    $rose(mod_active_out) |=> mod_out [*8])
    else $error("sync subcarrier does not open high");
  c_good: cover property (rx_event_out.frame_ok);
  c_bad: cover property (rx_event_out.frame_bad);
  c_answer: cover property ($rose(mod_active_out));
endmodule : frame_layer_sva

bind type_b_frame_layer frame_layer_sva #(.GUARD_CYC(GUARD_CYC))
  i_frame_layer_sva (
  .core_clk_in(core_clk_in),
  .reset_in(reset_in),
  .rx_event_out(rx_event_out),
  .mod_out(mod_out),
  .mod_active_out(mod_active_out),
  .tx_busy_out(tx_busy_out)
);

// *** testbench/reader_model.sv ***
`timescale 1ns/1ps

module reader_model #(
  parameter int ETU = 944
) (
  input wire logic clk_in,
  output logic level_out,
  input wire logic mod_in,
  input wire logic mod_active_in
);
  logic bits_q[$];
  int t_reg;
  initial level_out = 1'b1;

  task automatic hold(input logic v, input int etus);
    level_out = v;
    repeat (etus * ETU) @(posedge clk_in);
    #1;
  endtask : hold

  // A stalled request keeps the line high past the opener on purpose.
  task automatic request(input logic [7:0] q[$], input bit stall);
    hold(1'b0, 10);
    hold(1'b1, 2);
    if (stall) begin
      hold(1'b1, 2);
      return;
    end
    foreach (q[i]) begin
      hold(1'b0, 1);
      for (int b = 0; b < 8; b++) hold(q[i][b], 1);
      hold(1'b1, 1);
    end
    hold(1'b0, 10);
    hold(1'b1, 1);
  endtask : request

  // Sampling mid-bit in a high half of the sync phase gives 1 for in-phase.
  always @(posedge clk_in) begin
    if (!mod_active_in) begin
      t_reg <= 0;
    end else begin
      if (t_reg % ETU == 501) bits_q.push_back(mod_in);
      t_reg <= t_reg + 1;
    end
  end
endmodule : reader_model

// *** testbench/contactless_type_b_frame_layer_bench.sv ***
`timescale 1ns/1ps

module contactless_type_b_frame_layer_bench;
  import type_b_frame_pkg::*;
  localparam int GUARD = 1888;
  logic core_clk_in, reset_in, rx_level, tx_valid, tx_ready;
  logic mod, mod_active, tx_busy;
  rx_event_t rx_event;
  tx_word_t tx_word;
  int errors = 0, comparisons = 0, oks = 0, bads = 0, bytes = 0;
  logic [7:0] rx_data = 8'h00;
  logic exp_q[$];

  type_b_frame_layer #(.GUARD_CYC(GUARD), .SYNC_CYC(GUARD))
    i_type_b_frame_layer (
    .core_clk_in(core_clk_in), .reset_in(reset_in),
    .rx_level_in(rx_level), .rx_event_out(rx_event),
    .tx_word_in(tx_word), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready), .mod_out(mod),
    .mod_active_out(mod_active), .tx_busy_out(tx_busy)
  );
  reader_model i_reader_model (.clk_in(core_clk_in),
    .level_out(rx_level), .mod_in(mod), .mod_active_in(mod_active));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    if (!reset_in) begin
      oks += (rx_event.frame_ok === 1'b1);
      bads += (rx_event.frame_bad === 1'b1);
      bytes += (rx_event.byte_valid === 1'b1);
      if (rx_event.byte_valid === 1'b1) rx_data = rx_event.data;
    end
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return ~c;
  endfunction : crc16

  task automatic add_char(input logic [7:0] b);
    exp_q.push_back(1'b0);
    for (int i = 0; i < 8; i++) exp_q.push_back(b[i]);
    exp_q.push_back(1'b1);
  endtask : add_char

  task automatic add_delim;
    repeat (10) exp_q.push_back(1'b0);
    repeat (2) exp_q.push_back(1'b1);
  endtask : add_delim

  task automatic t_bad_sof;
    logic [7:0] none[$];
    i_reader_model.request(none, 1'b1);
    check("frame_bad", bads, 1);
    check("frame_ok", oks, 0);
    check("tx_busy", tx_busy, 0);
    $display("t_bad_sof finished");
  endtask : t_bad_sof

  // A flipped CRC bit must drop the frame with no answer at all.
  task automatic t_bad_crc;
    logic [7:0] req[$];
    logic [15:0] c;
    req = '{8'h5a};
    c = crc16(req) ^ 16'h0001;
    req.push_back(c[7:0]);
    req.push_back(c[15:8]);
    i_reader_model.request(req, 1'b0);
    check("frame_bad", bads, 2);
    check("frame_ok", oks, 0);
    check("byte_valid", bytes, 1);
    check("request byte", rx_data, 8'h5a);
    check("tx_busy", tx_busy, 0);
    $display("t_bad_crc finished");
  endtask : t_bad_crc

  task automatic t_answer;
    logic [7:0] req[$];
    logic [7:0] ans[$];
    logic [15:0] c;
    int n;
    ans = '{8'ha5};
    c = crc16(req);
    req = '{c[7:0], c[15:8]};
    tx_word = '{last: 1'b1, data: ans[0]};
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) begin
      @(posedge core_clk_in);
      #1;
    end
    @(posedge core_clk_in);
    #1 tx_valid = 1'b0;
    i_reader_model.request(req, 1'b0);
    check("frame_ok", oks, 1);
    check("byte_valid", bytes, 1);
    exp_q = '{1'b1, 1'b1};
    add_delim();
    add_char(ans[0]);
    c = crc16(ans);
    add_char(c[7:0]);
    add_char(c[15:8]);
    add_delim();
    for (n = 0; n < 5000 && mod_active !== 1'b1; n++) begin
      @(posedge core_clk_in);
      #1;
    end
    for (n = 0; n < 60000 && mod_active !== 1'b0; n++) begin
      @(posedge core_clk_in);
      #1;
    end
    check("bit count", i_reader_model.bits_q.size(), exp_q.size());
    foreach (exp_q[i]) begin
      check("answer bit", i_reader_model.bits_q[i], exp_q[i]);
    end
    // The next request may only follow once the quiet time has run out.
    for (n = 0; n < 3000 && tx_busy !== 1'b0; n++) begin
      @(posedge core_clk_in);
      #1;
    end
    check("tx_busy after", tx_busy, 0);
    $display("t_answer finished");
  endtask : t_answer

  // Nothing drains the buffer while idle, so it must refuse the ninth word.
  task automatic t_fill;
    int taken;
    taken = 0;
    tx_word = '{last: 1'b0, data: 8'h3c};
    tx_valid = 1'b1;
    repeat (10) begin
      taken += (tx_ready === 1'b1);
      @(posedge core_clk_in);
      #1;
    end
    tx_valid = 1'b0;
    check("words taken", taken, 8);
    check("tx_ready full", tx_ready, 0);
    $display("t_fill finished");
  endtask : t_fill

  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  initial begin
    reset_in = 1'b1;
    tx_valid = 1'b0;
    tx_word = '0;
    repeat (6) @(posedge core_clk_in);
    #1 reset_in = 1'b0;
    repeat (5) @(posedge core_clk_in);
    #1;
    t_bad_sof();
    t_bad_crc();
    t_answer();
    t_fill();
    results();
  end
  initial begin
    repeat (200000) @(posedge core_clk_in);
    errors++;
    results();
  end
endmodule : contactless_type_b_frame_layer_bench
